/* design/aecs_top.v */
// Exposure-loop status registers and sequencer configuration word.
// Assumes a serial front end that presents decoded register strobes
// on clk_i; frame statistics come from the pixel pipeline on clk_i.
//
// Notes on behaviour
// [R1] 19-bit sampled pixel count split: bits 15..0 low word, 18..16 high word.
// [R2] Loop mean in bits 9..0 and lock flag in bit 12 of mean word.
// [R3] Gain word: first analog code 1..0, second 3..2, digital 15..4.
// [R4] Config bit 0 runs sequencer when set; resets to idle.
// [R5] Config bit 1 selects rolling shutter; resets to global shutter.
// [R6] Loop steers exposure and gain toward 10-bit target, default 184.
// [R7] All status words update together from one frame's statistics.
`include "aecs_regs.vh"

module aecs_top (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Register access from serial front end
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [8:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    output reg  [15:0] reg_rdata_o,
    output reg         reg_rvalid_o,
    // Frame statistics from pixel pipeline
    input  wire        frame_done_i,
    input  wire [18:0] frame_count_i,
    input  wire [9:0]  frame_mean_i,
    // Sequencer controls
    output wire        seq_enable_o,
    output wire        rolling_shutter_o,
    // Applied exposure settings
    output wire [15:0] integ_o,
    output wire [1:0]  analog_amp_first_o,
    output wire [1:0]  analog_amp_second_o,
    output wire [11:0] digital_gain_o
);
    // Writable registers
    reg  [15:0] ctrl_r;
    reg  [9:0]  target_r;
    reg  [15:0] tune_r [0:6];
    // Status snapshot
    reg  [18:0] cnt_r;
    reg  [9:0]  mean_r;
    reg         lock_r;
    reg  [15:0] integ_r;
    reg  [15:0] amp_r;
    reg  [15:0] rdata_nxt;
    // Loop outputs and the statistics held for one cycle
    wire        upd_w;
    wire [15:0] l_integ_w;
    wire [1:0]  l_a1_w;
    wire [1:0]  l_a2_w;
    wire [11:0] l_dg_w;
    wire        l_lock_w;
    reg  [18:0] pend_cnt_r;
    reg  [9:0]  pend_mean_r;
    integer     i;

    // Tuning index from address, 7 when outside the tuning range
    function [2:0] tune_idx;
        input [8:0] a;
        reg   [8:0] off;
        begin
            off = a - `AECS_ADDR_TUNE_A; // Only the low bits matter inside the range
            if (a >= `AECS_ADDR_TUNE_A && a <= `AECS_ADDR_TUNE_G)
                tune_idx = off[2:0];
            else
                tune_idx = 3'h7;
        end
    endfunction

    aecs_loop #(
        .EXP_W (16)
    ) u_loop (
        .clk_i               (clk_i),
        .rst_n_i             (rst_n_i),
        .run_i               (ctrl_r[`AECS_CTRL_ENABLE]),
        .target_i            (target_r),
        .frame_done_i        (frame_done_i),
        .frame_mean_i        (frame_mean_i),
        .upd_o               (upd_w),
        .integ_o             (l_integ_w),
        .analog_amp_first_o  (l_a1_w),
        .analog_amp_second_o (l_a2_w),
        .dgain_o             (l_dg_w),
        .lock_o              (l_lock_w)
    );

    assign seq_enable_o        = ctrl_r[`AECS_CTRL_ENABLE];  // [R4]
    assign rolling_shutter_o   = ctrl_r[`AECS_CTRL_ROLLING]; // [R5]
    assign integ_o             = l_integ_w;
    assign analog_amp_first_o  = l_a1_w;
    assign analog_amp_second_o = l_a2_w;
    assign digital_gain_o      = l_dg_w;

    // Host writes; status registers ignore writes
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_r   <= `AECS_RST_CTRL;   // [R4] [R5]
            target_r <= `AECS_RST_TARGET; // [R6]
            tune_r[0] <= `AECS_RST_TUNE_A;
            tune_r[1] <= `AECS_RST_TUNE_B;
            tune_r[2] <= `AECS_RST_TUNE_C;
            tune_r[3] <= `AECS_RST_TUNE_D;
            tune_r[4] <= `AECS_RST_TUNE_E;
            tune_r[5] <= `AECS_RST_TUNE_F;
            tune_r[6] <= `AECS_RST_TUNE_G;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `AECS_ADDR_CTRL)
                ctrl_r <= {1'b0, reg_wdata_i[14:0]};
            if (reg_addr_i == `AECS_ADDR_TARGET)
                target_r <= reg_wdata_i[9:0]; // [R6]
            for (i = 0; i < 7; i = i + 1)
                if (tune_idx(reg_addr_i) == i[2:0])
                    tune_r[i] <= {6'h00, reg_wdata_i[9:0]};
        end
    end

    // Statistics held until the loop result of the same frame is ready,
    // so count, mean, lock, exposure and gain always belong together
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            pend_cnt_r  <= 19'h00000;
            pend_mean_r <= 10'h000;
            cnt_r       <= 19'h00000;
            mean_r      <= 10'h000;
            lock_r      <= 1'b0;
            integ_r     <= 16'h0000;
            amp_r       <= 16'h0000;
        end else begin
            if (frame_done_i) begin
                pend_cnt_r  <= frame_count_i;
                pend_mean_r <= frame_mean_i;
            end
            if (upd_w) begin
                cnt_r   <= pend_cnt_r;                    // [R1] [R7]
                mean_r  <= pend_mean_r;                   // [R2] [R7]
                lock_r  <= l_lock_w;                      // [R2] [R7]
                integ_r <= l_integ_w;                     // [R7]
                amp_r   <= {l_dg_w, l_a2_w, l_a1_w};      // [R3] [R7]
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr_i)
            `AECS_ADDR_CNT_LO: rdata_nxt = cnt_r[15:0];                  // [R1]
            `AECS_ADDR_CNT_HI: rdata_nxt = {13'h0000, cnt_r[18:16]};    // [R1]
            `AECS_ADDR_MEAN:   rdata_nxt = {3'h0, lock_r, 2'h0, mean_r}; // [R2]
            `AECS_ADDR_INTEG:  rdata_nxt = integ_r;
            `AECS_ADDR_AMP:    rdata_nxt = amp_r;                        // [R3]
            `AECS_ADDR_CTRL:   rdata_nxt = ctrl_r;
            `AECS_ADDR_TARGET: rdata_nxt = {6'h00, target_r};
            `AECS_ADDR_SPARE:  rdata_nxt = 16'h0000;
            default: begin
                if (tune_idx(reg_addr_i) != 3'h7)
                    rdata_nxt = tune_r[tune_idx(reg_addr_i)];
            end
        endcase
    end

    // Registered read answer one cycle after the strobe
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= 16'h0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
                reg_rdata_o <= rdata_nxt;
        end
    end
endmodule // aecs_top

/* design/aecs_regs.vh */
// Register addresses, field positions, reset values and loop constants
// for the exposure-status and sequencer-configuration register slice.
// Assumes 9-bit register addresses and 16-bit register data.
`ifndef AECS_REGS_VH
`define AECS_REGS_VH

// Register addresses
`define AECS_ADDR_TUNE_A      9'h0af
`define AECS_ADDR_TUNE_B      9'h0b0
`define AECS_ADDR_TUNE_C      9'h0b1
`define AECS_ADDR_TUNE_D      9'h0b2
`define AECS_ADDR_TUNE_E      9'h0b3
`define AECS_ADDR_TUNE_F      9'h0b4
`define AECS_ADDR_TUNE_G      9'h0b5
`define AECS_ADDR_CNT_LO      9'h0b8
`define AECS_ADDR_CNT_HI      9'h0b9
`define AECS_ADDR_MEAN        9'h0ba
`define AECS_ADDR_INTEG       9'h0bb
`define AECS_ADDR_AMP         9'h0bc
`define AECS_ADDR_SPARE       9'h0bd
`define AECS_ADDR_CTRL        9'h0c0
`define AECS_ADDR_TARGET      9'h0a1

// Reset values
`define AECS_RST_TUNE_A       16'h0080
`define AECS_RST_TUNE_B       16'h0100
`define AECS_RST_TUNE_C       16'h0100
`define AECS_RST_TUNE_D       16'h0080
`define AECS_RST_TUNE_E       16'h00aa
`define AECS_RST_TUNE_F       16'h0100
`define AECS_RST_TUNE_G       16'h0155
`define AECS_RST_CTRL         16'h0000
`define AECS_RST_TARGET       10'h0b8
`define AECS_RST_INTEG        16'h03ff
`define AECS_RST_DGAIN        12'h080

// Field positions and loop lock band
`define AECS_CTRL_ENABLE      0
`define AECS_CTRL_ROLLING     1
`define AECS_MEAN_LOCK        12
`define AECS_LOCK_BAND        10'h004

`endif

/* design/aecs_loop.v */
// Exposure loop: nudges exposure and gain once per frame toward target.
// Assumes frame statistics arrive with a one-cycle frame_done pulse.
`include "aecs_regs.vh"

module aecs_loop #(
    parameter EXP_W = 16
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // Controls
    input  wire             run_i,
    input  wire [9:0]       target_i,
    input  wire             frame_done_i,
    input  wire [9:0]       frame_mean_i,
    // Outputs
    output reg              upd_o,
    output reg  [EXP_W-1:0] integ_o,
    output reg  [1:0]       analog_amp_first_o,
    output reg  [1:0]       analog_amp_second_o,
    output reg  [11:0]      dgain_o,
    output reg              lock_o
);
    wire [9:0] diff_w;
    wire       high_w;

    assign high_w = frame_mean_i > target_i;
    assign diff_w = high_w ? (frame_mean_i - target_i) : (target_i - frame_mean_i);

    // One step per frame; dark: integration first, then gain when saturated; bright: gain down to default first
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            upd_o               <= 1'b0;
            integ_o             <= `AECS_RST_INTEG;
            analog_amp_first_o  <= 2'h0;
            analog_amp_second_o <= 2'h0;
            dgain_o             <= `AECS_RST_DGAIN;
            lock_o              <= 1'b0;
        end else begin
            upd_o <= run_i & frame_done_i;
            if (run_i && frame_done_i) begin
                lock_o <= (diff_w <= `AECS_LOCK_BAND); // [R6]
                if (diff_w > `AECS_LOCK_BAND) begin
                    if (high_w) begin
                        if (dgain_o > `AECS_RST_DGAIN)
                            dgain_o <= dgain_o - 12'h001;
                        else if (integ_o > {{(EXP_W-1){1'b0}}, 1'b1})
                            integ_o <= integ_o - {{(EXP_W-1){1'b0}}, 1'b1}; // [R6]
                    end else begin
                        if (integ_o != {EXP_W{1'b1}})
                            integ_o <= integ_o + {{(EXP_W-1){1'b0}}, 1'b1}; // [R6]
                        else if (dgain_o != 12'hfff)
                            dgain_o <= dgain_o + 12'h001;
                    end
                end
            end
        end
    end
endmodule // aecs_loop

/* tb/aecs_top_props.sv */
// Port checker for the exposure-status register slice.
// Assumes one clk_i domain with synchronous active-low rst_n_i.
`include "aecs_regs.vh"
module aecs_top_props (
    input wire        clk_i, rst_n_i, reg_wr_i, reg_rd_i, frame_done_i,
    input wire [8:0]  reg_addr_i,
    input wire [15:0] reg_wdata_i, reg_rdata_o, integ_o,
    input wire        reg_rvalid_o, seq_enable_o, rolling_shutter_o,
    input wire [18:0] frame_count_i,
    input wire [9:0]  frame_mean_i,
    input wire [1:0]  analog_amp_first_o, analog_amp_second_o,
    input wire [11:0] digital_gain_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Control word strobes and the applied settings as one vector
    wire        cw   = reg_wr_i && reg_addr_i == `AECS_ADDR_CTRL;
    wire        cr   = reg_rd_i && reg_addr_i == `AECS_ADDR_CTRL;
    wire [31:0] appl = {integ_o, analog_amp_first_o, analog_amp_second_o, digital_gain_o};
    rd_valid_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read without valid");
    rd_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("valid without read");
    run_wr_a: assert property (cw |=> seq_enable_o == $past(reg_wdata_i[0]))
        else $error("enable bit not written");
    shut_wr_a: assert property (cw |=> rolling_shutter_o == $past(reg_wdata_i[1]))
        else $error("shutter bit not written");
    ctl_hold_a: assert property (!cw |=> $stable({seq_enable_o, rolling_shutter_o}))
        else $error("control bits moved");
    ctl_read_a: assert property (cr |=> reg_rdata_o[1:0] == $past({rolling_shutter_o, seq_enable_o}))
        else $error("control readback wrong");
    idle_frame_a: assert property (frame_done_i && !seq_enable_o |=> $stable(appl))
        else $error("idle loop moved");
    loop_quiet_a: assert property (!frame_done_i |=> $stable(appl))
        else $error("settings moved without frame");
    cnt_hi_a: assert property (reg_rd_i && reg_addr_i == `AECS_ADDR_CNT_HI |=> reg_rdata_o[15:3] == 13'h0000)
        else $error("count high word too wide");
    // Main scenarios reached
    cover property (cw ##1 seq_enable_o);
    cover property (frame_done_i && seq_enable_o);
    cover property (reg_rvalid_o && reg_rdata_o[12]);
endmodule // aecs_top_props

bind aecs_top aecs_top_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .frame_done_i(frame_done_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .integ_o(integ_o),
    .reg_rvalid_o(reg_rvalid_o), .seq_enable_o(seq_enable_o),
    .rolling_shutter_o(rolling_shutter_o), .frame_count_i(frame_count_i),
    .frame_mean_i(frame_mean_i), .analog_amp_first_o(analog_amp_first_o),
    .analog_amp_second_o(analog_amp_second_o), .digital_gain_o(digital_gain_o));

/* tb/aecs_pix_src.sv */
// Pixel-pipeline stand-in: posts one frame's statistics on request.
// Assumes send is called from the bench's main process.
module aecs_pix_src (
    input  wire        clk_i,
    output reg         frame_done_o,
    output reg  [18:0] frame_count_o,
    output reg  [9:0]  frame_mean_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        frame_done_o  = 1'b0;
        frame_count_o = 19'h00000;
        frame_mean_o  = 10'h000;
    end
    // One-cycle strobe; lines then invert so stale data never looks valid
    task send(input [18:0] cnt, input [9:0] mean);
        @(negedge clk_i);
        frame_count_o = cnt;
        frame_mean_o  = mean;
        frame_done_o  = 1'b1;
        @(negedge clk_i);
        frame_done_o  = 1'b0;
        frame_count_o = ~cnt;
        frame_mean_o  = ~mean;
    endtask
endmodule // aecs_pix_src

/* tb/test_aecs_top.sv */
// Self-checking bench for the exposure-status register slice.
// Assumes all inputs change at falling edges of a 50 MHz clock.
module test_aecs_top;
    timeunit 1ns;
    timeprecision 1ns;
    reg         clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg         reg_wr_i = 1'b0;
    reg         reg_rd_i = 1'b0;
    reg  [8:0]  reg_addr_i = 9'h000;
    reg  [15:0] reg_wdata_i = 16'h0000;
    reg  [15:0] prev;
    wire [15:0] reg_rdata_o, integ_o;
    wire        reg_rvalid_o, seq_enable_o, rolling_shutter_o, frame_done_i;
    wire [18:0] frame_count_i;
    wire [9:0]  frame_mean_i;
    wire [1:0]  amp1, amp2;
    wire [11:0] dgain;
    integer     errors = 0;
    integer     num_checks = 0;
    integer     i;
    localparam logic [8:0]  ADR [16] = '{9'h0af, 9'h0b0, 9'h0b1, 9'h0b2, 9'h0b3, 9'h0b4,
        9'h0b5, 9'h0b8, 9'h0b9, 9'h0ba, 9'h0bb, 9'h0bc, 9'h0bd, 9'h0c0, 9'h0a1, 9'h0ff};
    localparam logic [15:0] RST [16] = '{16'h0080, 16'h0100, 16'h0100, 16'h0080, 16'h00aa,
        16'h0100, 16'h0155, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h00b8, 16'h0};
    always #10 clk_i = ~clk_i;
    aecs_pix_src u_src (.clk_i(clk_i), .frame_done_o(frame_done_i),
        .frame_count_o(frame_count_i), .frame_mean_o(frame_mean_i));
    aecs_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .frame_done_i(frame_done_i),
        .frame_count_i(frame_count_i), .frame_mean_i(frame_mean_i),
        .seq_enable_o(seq_enable_o), .rolling_shutter_o(rolling_shutter_o),
        .integ_o(integ_o), .analog_amp_first_o(amp1), .analog_amp_second_o(amp2),
        .digital_gain_o(dgain));
    // Four-state compare so an unknown never passes
    task chk(input string what, input [15:0] exp, input [15:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %0s exp %h got %h", what, exp, got);
        end
    endtask
    // Register cycles: strobe held over one rising edge
    task wr(input [8:0] a, input [15:0] d);
        @(negedge clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    task rdc(input string what, input [8:0] a, input [15:0] exp);
        integer n;
        @(negedge clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        n = 0;
        while (reg_rvalid_o !== 1'b1 && n < 4) begin
            @(negedge clk_i);
            n = n + 1;
        end
        chk(what, exp, reg_rdata_o);
    endtask
    task frame(input [18:0] c, input [9:0] m);
        u_src.send(c, m);
        repeat (3) @(negedge clk_i);
    endtask
    task test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog: run needs well under 10000 cycles
    initial begin
        #200000;
        errors = errors + 1;
        test_done;
    end
    initial begin
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        chk("integ_o", 16'h03ff, integ_o);
        chk("dgain", 16'h0080, {4'h0, dgain});
        chk("amps", 16'h0000, {12'h000, amp2, amp1});
        for (i = 0; i < 16; i = i + 1)
            rdc("reset", ADR[i], RST[i]);
        $display("test reset done");
        // Frame while idle must be ignored
        frame(19'h7ffff, 10'h3ff);
        rdc("cnt idle", 9'h0b8, 16'h0000);
        chk("integ idle", 16'h03ff, integ_o);
        wr(9'h0c0, 16'h8003);
        chk("enable", 16'h0001, {15'h0, seq_enable_o});
        chk("rolling", 16'h0001, {15'h0, rolling_shutter_o});
        rdc("ctrl", 9'h0c0, 16'h0003);
        wr(9'h0c0, 16'h0001);
        chk("global", 16'h0000, {15'h0, rolling_shutter_o});
        $display("test ctrl done");
        // On target: lock set, RO write ignored, both count words agree
        frame(19'h5a5a5, 10'h0b8);
        wr(9'h0b8, 16'hffff);
        rdc("cnt_lo", 9'h0b8, 16'ha5a5);
        rdc("cnt_hi", 9'h0b9, 16'h0005);
        rdc("mean", 9'h0ba, 16'h10b8);
        rdc("integ", 9'h0bb, 16'h03ff);
        rdc("amp", 9'h0bc, 16'h0800);
        $display("test lock done");
        // Bright frame shortens exposure, dark frame lengthens it
        frame(19'h70001, 10'h3ff);
        prev = integ_o;
        chk("dgain bright", 16'h0080, {4'h0, dgain});
        chk("darker", 16'h0001, {15'h0, prev < 16'h03ff});
        rdc("cnt_lo2", 9'h0b8, 16'h0001);
        rdc("cnt_hi2", 9'h0b9, 16'h0007);
        rdc("unlock", 9'h0ba, 16'h03ff);
        frame(19'h00010, 10'h000);
        chk("brighter", 16'h0001, {15'h0, integ_o > prev});
        chk("amps dark", 16'h0000, {12'h000, amp2, amp1});
        rdc("amp dark", 9'h0bc, 16'h0800);
        rdc("mean dark", 9'h0ba, 16'h0000);
        $display("test steer done");
        test_done;
    end
endmodule // test_aecs_top
